// ===== bps_pkg.sv
package bps_pkg;
   // ------------------------------------------------------------
   // clock and times
   // ------------------------------------------------------------
   localparam longint CLK_KHZ       = 64'h30d40;
   localparam longint OCC_DLY_MS    = 64'h3e8;
   localparam longint ODC1_DLY_MS   = 64'h2710;
   localparam longint ODC2_DLY_MS   = 64'h500;
   localparam longint OC_REL_MS     = 64'h2710;
   localparam longint SC_DLY_US     = 64'h190;
   localparam longint UV_DLY_MS     = 64'h3e8;
   localparam longint OD_SLP_S      = 64'h1e;
   localparam longint IDLE_SLP_MIN  = 64'h1e;
   localparam longint LED_SLOW_MS   = 64'h1f4;
   localparam longint LED_FAST_MS   = 64'h64;
   localparam longint OCC_DLY_CYC   = OCC_DLY_MS * CLK_KHZ;
   localparam longint ODC1_DLY_CYC  = ODC1_DLY_MS * CLK_KHZ;
   localparam longint ODC2_DLY_CYC  = ODC2_DLY_MS * CLK_KHZ;
   localparam longint OC_REL_CYC    = OC_REL_MS * CLK_KHZ;
   localparam longint SC_DLY_CYC    = SC_DLY_US * CLK_KHZ / 64'h3e8;
   localparam longint UV_DLY_CYC    = UV_DLY_MS * CLK_KHZ;
   localparam longint OD_SLP_CYC    = OD_SLP_S * 64'h3e8 * CLK_KHZ;
   localparam longint IDLE_SLP_CYC  = IDLE_SLP_MIN * 64'h3c * 64'h3e8 * CLK_KHZ;
   localparam longint LED_SLOW_CYC  = LED_SLOW_MS * CLK_KHZ;
   localparam longint LED_FAST_CYC  = LED_FAST_MS * CLK_KHZ;
   localparam int     TMR_W         = 40;
   // ------------------------------------------------------------
   // thresholds: current in A (charge positive; balance limit in mA), voltage in mV, temperature in degC
   // ------------------------------------------------------------
   localparam logic signed [15:0] OCC_A        = 16'sh014a;
   localparam logic signed [15:0] ODC1_A       = 16'sh015e;
   localparam logic signed [15:0] ODC2_A       = 16'sh0190;
   localparam logic signed [15:0] SC_A         = 16'sh0320;
   localparam logic signed [15:0] ACT_A        = 16'sh0001;
   localparam logic signed [15:0] HEAT_MAX_A   = 16'sh000a;
   localparam logic [19:0]        CELL_UV_MV   = 20'h00af0;
   localparam logic [19:0]        CELL_REL_MV  = 20'h00bb8;
   localparam logic [19:0]        PACK_UV_MV   = 20'h0dac0;
   localparam logic [19:0]        PACK_REL_MV  = 20'h0ea60;
   localparam logic [19:0]        BAL_START_MV = 20'h00fa0;
   localparam logic [19:0]        BAL_DIFF_MV  = 20'h00032;
   localparam logic [19:0]        WAKE_DIFF_MV = 20'h003e8;
   localparam logic [15:0]        BAL_MAX_MA   = 16'h07d0;
   localparam logic signed [7:0]  FET_OT_C     = 8'sh64;
   localparam logic signed [7:0]  FET_REL_C    = 8'sh46;
   localparam logic signed [7:0]  CHG_LT_C     = 8'sh00;
   localparam logic signed [7:0]  CHG_LT_REL_C = 8'sh05;
   localparam logic signed [7:0]  CHG_HT_C     = 8'sh3c;
   localparam logic signed [7:0]  CHG_HT_REL_C = 8'sh37;
   localparam logic signed [7:0]  DSG_LT_C     = -8'sh0f;
   localparam logic signed [7:0]  DSG_LT_REL_C = -8'sh0a;
   localparam logic signed [7:0]  DSG_HT_C     = 8'sh41;
   localparam logic signed [7:0]  DSG_HT_REL_C = 8'sh37;
   localparam logic signed [7:0]  HEAT_ON_C    = 8'sh00;
   localparam logic signed [7:0]  HEAT_OFF_C   = 8'sh05;
   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [3:0]  REG_CTRL     = 4'h0;
   localparam logic [3:0]  REG_STATUS   = 4'h4;
   localparam logic [3:0]  REG_INT_STAT = 4'h8;
   localparam logic [3:0]  REG_INT_MASK = 4'hc;
   localparam int          CTRL_MOM_BIT = 0;
   localparam logic [7:0]  INT_MASK_RST = 8'h00;
   localparam int          EV_SLEEP     = 6;
   localparam int          EV_WAKE      = 7;
   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      BPS_ST_WORK  = 2'b01,
      BPS_ST_SLEEP = 2'b10
   } bps_state_t;

   typedef struct packed {
      logic signed [15:0] current_a;
      logic [19:0]        cell_max_mv;
      logic [19:0]        cell_min_mv;
      logic [19:0]        pack_mv;
      logic [19:0]        charger_mv;
      logic signed [7:0]  bat_temp_c;
      logic signed [7:0]  fet_temp_c;
   } bps_meas_t;

   typedef struct packed {
      logic dsg_ht;
      logic dsg_lt;
      logic chg_ht;
      logic chg_lt;
      logic pack_uv;
      logic cell_uv;
      logic fet_ot;
      logic sc;
      logic dsg_oc;
      logic chg_oc;
   } bps_fault_t;

   typedef struct packed {
      logic        chg_path_en;
      logic        dsg_path_en;
      logic        heater_en;
      logic        bal_en;
      logic [15:0] bal_lim_ma;
      logic        radio_en;
      logic        led;
   } bps_out_t;
endpackage : bps_pkg

// ===== bps_dly_tmr.sv
`timescale 1ns/1ps
module bps_dly_tmr #(
   parameter int W = 40
) (
   input  wire logic         sys_clk,
   input  wire logic         srst,
   input  wire logic         arm,
   input  wire logic [W-1:0] limit,
   output logic              expired
);
   logic [W-1:0] cnt_ff;
   logic [W-1:0] nxt_cnt;

   // counter drops to zero as soon as the condition goes away
   always_comb begin
      if (!arm) begin
         nxt_cnt = '0;
      end else if (cnt_ff == limit) begin
         nxt_cnt = cnt_ff;
      end else begin
         nxt_cnt = cnt_ff + 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   assign expired = arm && (cnt_ff == limit);
endmodule : bps_dly_tmr

// ===== bps_supervisor.sv
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module bps_supervisor
   import bps_pkg::*;
#(
   parameter logic signed [15:0] OCC_THR_A    = bps_pkg::OCC_A,
   parameter logic signed [15:0] ODC1_THR_A   = bps_pkg::ODC1_A,
   parameter logic signed [15:0] ODC2_THR_A   = bps_pkg::ODC2_A,
   parameter logic signed [7:0]  FET_OT_THR_C = bps_pkg::FET_OT_C,
   parameter logic signed [7:0]  FET_REL_THR_C = bps_pkg::FET_REL_C,
   parameter longint             OCC_CYC      = bps_pkg::OCC_DLY_CYC,
   parameter longint             ODC1_CYC     = bps_pkg::ODC1_DLY_CYC,
   parameter longint             ODC2_CYC     = bps_pkg::ODC2_DLY_CYC,
   parameter longint             OC_REL_CYC_P = bps_pkg::OC_REL_CYC,
   parameter longint             SC_CYC       = bps_pkg::SC_DLY_CYC,
   parameter longint             UV_CYC       = bps_pkg::UV_DLY_CYC,
   parameter longint             OD_SLP_CYC_P = bps_pkg::OD_SLP_CYC,
   parameter longint             IDLE_CYC     = bps_pkg::IDLE_SLP_CYC,
   parameter longint             LED_SLOW_P   = bps_pkg::LED_SLOW_CYC,
   parameter longint             LED_FAST_P   = bps_pkg::LED_FAST_CYC
) (
   input  wire logic              sys_clk,
   input  wire logic              srst,
   input  wire bps_pkg::bps_meas_t meas,
   input  wire logic              switch_closed,
   input  wire logic              load_removed,
   input  wire logic              comm_activity,
   input  wire logic [3:0]        reg_addr,
   input  wire logic [31:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic [31:0]            reg_rdata,
   output bps_pkg::bps_out_t      outs,
   output logic                   irq
);
   import bps_pkg::*;

   // ------------------------------------------------------------
   // measurement decode
   // ------------------------------------------------------------
   localparam int NT = 10;
   localparam int T_OCC = 0, T_ODC1 = 1, T_ODC2 = 2, T_SC = 3, T_CUV = 4;
   localparam int T_PUV = 5, T_CREL = 6, T_DREL = 7, T_ODSLP = 8, T_IDLE = 9;

   logic signed [15:0] dsg_a;
   logic               charging;
   logic               discharging;
   logic               sw_on;
   logic               charger_wake;
   logic [20:0]        wake_mv;

   assign dsg_a       = -meas.current_a;
   assign charging    = meas.current_a > ACT_A;
   assign discharging = dsg_a > ACT_A;
   assign wake_mv     = {1'b0, meas.pack_mv} + {1'b0, WAKE_DIFF_MV};
   assign charger_wake = {1'b0, meas.charger_mv} >= wake_mv;

   // ------------------------------------------------------------
   // delay timers
   // ------------------------------------------------------------
   bps_fault_t                flt_ff;
   bps_fault_t                nxt_flt;
   bps_state_t                st_ff;
   bps_state_t                nxt_st;
   logic [NT-1:0]             arm;
   logic [NT-1:0]             tmo;
   logic [TMR_W-1:0]          lim [NT];

   assign lim[T_OCC]   = TMR_W'(OCC_CYC);
   assign lim[T_ODC1]  = TMR_W'(ODC1_CYC);
   assign lim[T_ODC2]  = TMR_W'(ODC2_CYC);
   assign lim[T_SC]    = TMR_W'(SC_CYC);
   assign lim[T_CUV]   = TMR_W'(UV_CYC);
   assign lim[T_PUV]   = TMR_W'(UV_CYC);
   assign lim[T_CREL]  = TMR_W'(OC_REL_CYC_P);
   assign lim[T_DREL]  = TMR_W'(OC_REL_CYC_P);
   assign lim[T_ODSLP] = TMR_W'(OD_SLP_CYC_P);
   assign lim[T_IDLE]  = TMR_W'(IDLE_CYC);

   always_comb begin
      arm          = '0;
      arm[T_OCC]   = meas.current_a > OCC_THR_A;
      arm[T_ODC1]  = dsg_a > ODC1_THR_A;
      arm[T_ODC2]  = dsg_a > ODC2_THR_A;
      arm[T_SC]    = dsg_a > SC_A;
      arm[T_CUV]   = meas.cell_min_mv < CELL_UV_MV;
      arm[T_PUV]   = meas.pack_mv < PACK_UV_MV;
      arm[T_CREL]  = flt_ff.chg_oc;
      arm[T_DREL]  = flt_ff.dsg_oc;
      arm[T_ODSLP] = (st_ff == BPS_ST_WORK) && (flt_ff.cell_uv || flt_ff.pack_uv) && !charging;
      // any current above ACT_A either way, or bus traffic, drops arm and so restarts the count
      arm[T_IDLE]  = (st_ff == BPS_ST_WORK) && !charging && !discharging && !comm_activity;
   end

   // each timer restarts from zero when its condition drops out
   genvar gi;
   generate
      for (gi = 0; gi < NT; gi++) begin : g_tmr
         bps_dly_tmr #(
            .W       (TMR_W)
         ) u_tmr (
            .sys_clk (sys_clk),
            .srst    (srst),
            .arm     (arm[gi]),
            .limit   (lim[gi]),
            .expired (tmo[gi])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // fault flags: a set in the same cycle as a clear wins
   // ------------------------------------------------------------
   always_comb begin
      nxt_flt = flt_ff;
      if (tmo[T_CREL] || discharging) begin
         nxt_flt.chg_oc = 1'b0;
      end
      if (tmo[T_OCC]) begin
         nxt_flt.chg_oc = 1'b1;
      end
      if (tmo[T_DREL] || charging) begin
         nxt_flt.dsg_oc = 1'b0;
      end
      if (tmo[T_ODC1] || tmo[T_ODC2]) begin
         nxt_flt.dsg_oc = 1'b1;
      end
      if (charging || load_removed) begin
         nxt_flt.sc = 1'b0;
      end
      if (tmo[T_SC]) begin
         nxt_flt.sc = 1'b1;
      end
      if (meas.fet_temp_c <= FET_REL_THR_C) begin
         nxt_flt.fet_ot = 1'b0;
      end
      if (meas.fet_temp_c >= FET_OT_THR_C) begin
         nxt_flt.fet_ot = 1'b1;
      end
      if (charging && meas.cell_min_mv > CELL_REL_MV) begin
         nxt_flt.cell_uv = 1'b0;
      end
      if (tmo[T_CUV]) begin
         nxt_flt.cell_uv = 1'b1;
      end
      if (charging && meas.pack_mv > PACK_REL_MV) begin
         nxt_flt.pack_uv = 1'b0;
      end
      if (tmo[T_PUV]) begin
         nxt_flt.pack_uv = 1'b1;
      end
      // battery temperature windows, each with its own release point
      if (meas.bat_temp_c >= CHG_LT_REL_C) nxt_flt.chg_lt = 1'b0;
      if (meas.bat_temp_c < CHG_LT_C)      nxt_flt.chg_lt = 1'b1;
      if (meas.bat_temp_c <= CHG_HT_REL_C) nxt_flt.chg_ht = 1'b0;
      if (meas.bat_temp_c > CHG_HT_C)      nxt_flt.chg_ht = 1'b1;
      if (meas.bat_temp_c >= DSG_LT_REL_C) nxt_flt.dsg_lt = 1'b0;
      if (meas.bat_temp_c < DSG_LT_C)      nxt_flt.dsg_lt = 1'b1;
      if (meas.bat_temp_c <= DSG_HT_REL_C) nxt_flt.dsg_ht = 1'b0;
      if (meas.bat_temp_c > DSG_HT_C)      nxt_flt.dsg_ht = 1'b1;
   end

   // ------------------------------------------------------------
   // switch and sleep state machine
   // ------------------------------------------------------------
   logic [31:0] ctrl_ff;
   logic [31:0] nxt_ctrl;
   logic        sw_prev_ff;
   logic        sw_tgl_ff;
   logic        sw_on_prev_ff;
   logic        nxt_sw_tgl;
   logic        sw_rise;

   // momentary mode toggles on each press; latching follows the level
   assign sw_on   = ctrl_ff[CTRL_MOM_BIT] ? sw_tgl_ff : switch_closed;
   assign sw_rise = sw_on && !sw_on_prev_ff;

   always_comb begin
      nxt_sw_tgl = sw_tgl_ff;
      if (switch_closed && !sw_prev_ff) begin
         nxt_sw_tgl = !sw_tgl_ff;
      end
      nxt_st = st_ff;
      case (st_ff)
         BPS_ST_WORK: begin
            if (!sw_on) begin
               nxt_st = BPS_ST_SLEEP;
            end else if (tmo[T_ODSLP] || tmo[T_IDLE]) begin
               nxt_st = BPS_ST_SLEEP;
            end
         end
         BPS_ST_SLEEP: begin
            if (sw_rise) begin
               nxt_st = BPS_ST_WORK;
            end else if (sw_on && charger_wake) begin
               nxt_st = BPS_ST_WORK;
            end
         end
         default: begin
            nxt_st = BPS_ST_SLEEP;
         end
      endcase
   end

   // ------------------------------------------------------------
   // heating, balancing, led and outputs
   // ------------------------------------------------------------
   logic        heat_ff;
   logic        nxt_heat;
   logic [31:0] led_cnt_ff;
   logic [31:0] nxt_led_cnt;
   logic [31:0] led_half;
   logic        abnormal;
   logic        working;
   logic [19:0] spread_mv;
   bps_out_t    outs_ff;
   bps_out_t    nxt_outs;

   assign working   = st_ff == BPS_ST_WORK;
   assign abnormal  = |flt_ff;
   assign spread_mv = meas.cell_max_mv - meas.cell_min_mv;
   // fast rate whenever anything is wrong
   assign led_half  = abnormal ? 32'(LED_FAST_P) : 32'(LED_SLOW_P);

   always_comb begin
      nxt_heat = heat_ff;
      if (!working || !charger_wake || meas.bat_temp_c >= HEAT_OFF_C) begin
         nxt_heat = 1'b0;
      end else if (meas.bat_temp_c <= HEAT_ON_C) begin
         nxt_heat = 1'b1;
      end
      nxt_led_cnt = led_cnt_ff + 32'h1;
      nxt_outs    = outs_ff;
      if (led_cnt_ff >= led_half - 32'h1) begin
         nxt_led_cnt  = 32'h0;
         nxt_outs.led = !outs_ff.led;
      end
      // sleep holds both paths off and the radio down
      nxt_outs.chg_path_en = working && !flt_ff.chg_oc && !flt_ff.fet_ot && !flt_ff.sc
                             && !flt_ff.chg_lt && !flt_ff.chg_ht;
      nxt_outs.dsg_path_en = working && !flt_ff.dsg_oc && !flt_ff.fet_ot && !flt_ff.sc
                             && !flt_ff.cell_uv && !flt_ff.pack_uv
                             && !flt_ff.dsg_lt && !flt_ff.dsg_ht;
      nxt_outs.radio_en    = working;
      // heater pauses while the charger pushes more than the heater may draw
      nxt_outs.heater_en   = heat_ff && (meas.current_a <= HEAT_MAX_A);
      nxt_outs.bal_en      = working && meas.cell_max_mv >= BAL_START_MV
                             && spread_mv >= BAL_DIFF_MV;
      nxt_outs.bal_lim_ma  = nxt_outs.bal_en ? BAL_MAX_MA : 16'h0;
   end

   // ------------------------------------------------------------
   // registers, interrupts and bus
   // ------------------------------------------------------------
   logic [7:0]  int_stat_ff;
   logic [7:0]  nxt_int_stat;
   logic [7:0]  int_mask_ff;
   logic [7:0]  nxt_int_mask;
   logic [7:0]  events;
   logic [31:0] nxt_rdata;
   logic        irq_ff;

   assign events = {(nxt_st == BPS_ST_WORK) && !working,
                    (nxt_st == BPS_ST_SLEEP) && working,
                    nxt_flt.pack_uv & ~flt_ff.pack_uv,
                    nxt_flt.cell_uv & ~flt_ff.cell_uv,
                    nxt_flt.fet_ot  & ~flt_ff.fet_ot,
                    nxt_flt.sc      & ~flt_ff.sc,
                    nxt_flt.dsg_oc  & ~flt_ff.dsg_oc,
                    nxt_flt.chg_oc  & ~flt_ff.chg_oc};

   always_comb begin
      nxt_ctrl     = ctrl_ff;
      nxt_int_mask = int_mask_ff;
      nxt_int_stat = int_stat_ff;
      nxt_rdata    = 32'h0;
      if (reg_wr) begin
         if (reg_addr == REG_CTRL) begin
            nxt_ctrl = {31'h0, reg_wdata[CTRL_MOM_BIT]};
         end else if (reg_addr == REG_INT_STAT) begin
            nxt_int_stat = int_stat_ff & ~reg_wdata[7:0];
         end else if (reg_addr == REG_INT_MASK) begin
            nxt_int_mask = reg_wdata[7:0];
         end
      end
      // an event in the clearing cycle stays set
      nxt_int_stat = nxt_int_stat | events;
      if (reg_rd) begin
         if (reg_addr == REG_CTRL) begin
            nxt_rdata = ctrl_ff;
         end else if (reg_addr == REG_STATUS) begin
            nxt_rdata = {18'h0, st_ff, sw_on, abnormal, flt_ff};
         end else if (reg_addr == REG_INT_STAT) begin
            nxt_rdata = {24'h0, int_stat_ff};
         end else if (reg_addr == REG_INT_MASK) begin
            nxt_rdata = {24'h0, int_mask_ff};
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         flt_ff        <= '0;
         st_ff         <= BPS_ST_SLEEP;
         ctrl_ff       <= 32'h0;
         sw_prev_ff    <= 1'b0;
         sw_tgl_ff     <= 1'b0;
         sw_on_prev_ff <= 1'b0;
         heat_ff       <= 1'b0;
         led_cnt_ff    <= 32'h0;
         outs_ff       <= '0;
         int_stat_ff   <= 8'h0;
         int_mask_ff   <= INT_MASK_RST;
         reg_rdata     <= 32'h0;
         irq_ff        <= 1'b0;
      end else begin
         flt_ff        <= nxt_flt;
         st_ff         <= nxt_st;
         ctrl_ff       <= nxt_ctrl;
         sw_prev_ff    <= switch_closed;
         sw_tgl_ff     <= nxt_sw_tgl;
         sw_on_prev_ff <= sw_on;
         heat_ff       <= nxt_heat;
         led_cnt_ff    <= nxt_led_cnt;
         outs_ff       <= nxt_outs;
         int_stat_ff   <= nxt_int_stat;
         int_mask_ff   <= nxt_int_mask;
         reg_rdata     <= nxt_rdata;
         irq_ff        <= |(nxt_int_stat & nxt_int_mask);
      end
   end

   assign outs = outs_ff;
   assign irq  = irq_ff;
endmodule : bps_supervisor

// ===== bps_front_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// measurement front end model
// ------------------------------------------------------------
module bps_front_model
   import bps_pkg::*;
(
   input  wire logic               sys_clk,
   input  wire logic signed [15:0] cur_a,
   input  wire logic [19:0]        cmax_mv,
   input  wire logic [19:0]        cmin_mv,
   input  wire logic signed [7:0]  bat_c,
   input  wire logic signed [7:0]  fet_c,
   input  wire logic               chg_on,
   output bps_pkg::bps_meas_t      meas
);
   // one conversion a clock; an attached charger sits exactly 1 V above the pack, the wake edge
   always_ff @(posedge sys_clk) begin
      meas <= '{cur_a, cmax_mv, cmin_mv, 20'h0ea60, chg_on ? 20'h0ee48 : 20'h0ea60, bat_c, fet_c};
   end
endmodule : bps_front_model

// ===== bps_supervisor_props.sv
`timescale 1ns/1ps
module bps_supervisor_props
   import bps_pkg::*;
#(
   parameter longint OCC_CYC  = 20,
   parameter longint ODC2_CYC = 20
) (
   input wire logic               sys_clk,
   input wire logic               srst,
   input wire bps_pkg::bps_meas_t meas,
   input wire logic               reg_rd,
   input wire logic [31:0]        reg_rdata,
   input wire bps_pkg::bps_out_t  outs
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   logic [15:0] occ_ff, odc_ff, nxt_occ, nxt_odc;
   // run lengths of overcurrent; checked at one instant only, since auto release may follow
   always_comb begin
      nxt_occ = (meas.current_a > OCC_A) ? occ_ff + 16'h0001 : 16'h0000;
      nxt_odc = (meas.current_a < -ODC2_A) ? odc_ff + 16'h0001 : 16'h0000;
   end
   always_ff @(posedge sys_clk) begin
      occ_ff <= srst ? 16'h0000 : nxt_occ;
      odc_ff <= srst ? 16'h0000 : nxt_odc;
   end
   sequence s_fet_hot;
      meas.fet_temp_c >= FET_OT_C;
   endsequence
   sequence s_paths_off;
      !outs.chg_path_en && !outs.dsg_path_en;
   endsequence
   AST_FET_OT: assert property (s_fet_hot |-> ##2 s_paths_off)
      else $error("transistor overheat left a path on");
   AST_CHG_HT: assert property (meas.bat_temp_c > CHG_HT_C |-> ##2 !outs.chg_path_en)
      else $error("charge path on while too hot");
   AST_DSG_LT: assert property (meas.bat_temp_c < DSG_LT_C |-> ##2 !outs.dsg_path_en)
      else $error("discharge path on while too cold");
   AST_OCC: assert property (occ_ff == OCC_CYC + 3 |-> !outs.chg_path_en)
      else $error("charge overcurrent did not open path");
   AST_ODC2: assert property (odc_ff == ODC2_CYC + 3 |-> !outs.dsg_path_en)
      else $error("discharge overcurrent did not open path");
   AST_BAL_LIM: assert property (outs.bal_lim_ma == (outs.bal_en ? BAL_MAX_MA : 16'h0000))
      else $error("balance limit wrong");
   AST_BAL_COND: assert property (outs.bal_en |-> $past(meas.cell_max_mv) >= BAL_START_MV &&
      $past(meas.cell_max_mv) - $past(meas.cell_min_mv) >= BAL_DIFF_MV)
      else $error("balancing without cause");
   AST_HEAT_CUR: assert property (outs.heater_en |-> $past(meas.current_a) <= HEAT_MAX_A)
      else $error("heater on above current limit");
   AST_SLEEP_OFF: assert property (!outs.radio_en |-> s_paths_off)
      else $error("path on while asleep");
   AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside its cycle");
endmodule : bps_supervisor_props
bind bps_supervisor bps_supervisor_props #(.OCC_CYC(OCC_CYC), .ODC2_CYC(ODC2_CYC)) bps_supervisor_props_i (
   .sys_clk(sys_clk), .srst(srst), .meas(meas), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .outs(outs));

// ===== tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
   $display("MISMATCH %s exp=%h got=%h", n, e, g); end end
module tb_top;
   import bps_pkg::*;
   logic               sys_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, irq;
   logic               switch_closed = 1'b0, load_removed = 1'b0, comm_activity = 1'b1, chg_on = 1'b0;
   logic [3:0]         reg_addr = 4'h0;
   logic [31:0]        reg_wdata = 32'h0, reg_rdata, rv;
   logic signed [15:0] cur_a = 16'sh0000;
   logic [19:0]        cmax_mv = 20'h00e74, cmin_mv = 20'h00e74;
   logic signed [7:0]  bat_c = 8'sh19, fet_c = 8'sh19;
   logic signed [7:0]  t_bat [11] = '{8'sh3d, 8'sh38, 8'sh37, 8'sh42, 8'sh37, -8'sh10, -8'sh0a, 8'sh05,
                                      8'sh19, 8'sh19, 8'sh19};
   logic signed [7:0]  t_fet [11] = '{8'sh19, 8'sh19, 8'sh19, 8'sh19, 8'sh19, 8'sh19, 8'sh19, 8'sh19,
                                      8'sh64, 8'sh47, 8'sh46};
   logic [9:0]         t_exp [11] = '{10'h080, 10'h080, 10'h000, 10'h280, 10'h000, 10'h140, 10'h040,
                                      10'h000, 10'h008, 10'h008, 10'h000};
   bps_meas_t          meas;
   bps_out_t           outs;
   int                 bad_count = 0, tests_run = 0;
   always #2.5 sys_clk = ~sys_clk;
   bps_front_model bps_front_model_i (.sys_clk(sys_clk), .cur_a(cur_a), .cmax_mv(cmax_mv), .cmin_mv(cmin_mv),
      .bat_c(bat_c), .fet_c(fet_c), .chg_on(chg_on), .meas(meas));
   // short delays keep the run brief; the others keep real values and are never reached here
   bps_supervisor #(.OCC_CYC(20), .ODC2_CYC(20), .OC_REL_CYC_P(30), .SC_CYC(10), .IDLE_CYC(60)) bps_supervisor_i (
      .sys_clk(sys_clk), .srst(srst), .meas(meas), .switch_closed(switch_closed), .load_removed(load_removed),
      .comm_activity(comm_activity), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .outs(outs), .irq(irq));
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : tick
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      @(negedge sys_clk);
      d = reg_rdata;
   endtask : rd
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      tick(20000);
      bad_count++;
      tally_and_finish();
   end
   initial begin
      tick(10);
      srst <= 1'b0;
      rd(REG_STATUS, rv);
      `CHK("state", 2'b10, rv[13:12])
      rd(4'h2, rv);
      `CHK("unmapped", 32'h0, rv)
      @(posedge sys_clk);
      switch_closed <= 1'b1;
      tick(4);
      rd(REG_STATUS, rv);
      `CHK("state", 2'b01, rv[13:12])
      rd(REG_INT_STAT, rv);
      `CHK("wake_ev", 1'b1, rv[EV_WAKE])
      wr(REG_INT_STAT, 32'hff);
      wr(REG_INT_MASK, 32'h01);
      $display("test wake done");
      cur_a <= 16'sh014b;
      tick(15);
      cur_a <= 16'sh0000;
      tick(1);
      cur_a <= 16'sh014b;
      tick(14);
      rd(REG_STATUS, rv);
      `CHK("chg_oc", 1'b0, rv[0])
      tick(12);
      cur_a <= 16'sh0000;
      `CHK("chg_path", 1'b0, outs.chg_path_en)
      `CHK("irq", 1'b1, irq)
      wr(REG_INT_MASK, 32'h00);
      tick(2);
      `CHK("irq_mask", 1'b0, irq)
      wr(REG_INT_MASK, 32'h01);
      tick(2);
      `CHK("irq_unmask", 1'b1, irq)
      wr(REG_INT_STAT, 32'h01);
      tick(2);
      `CHK("irq_clr", 1'b0, irq)
      tick(30);
      rd(REG_STATUS, rv);
      `CHK("chg_oc_rel", 1'b0, rv[0])
      @(posedge sys_clk);
      cur_a <= 16'shfe6f;
      tick(25);
      cur_a <= 16'sh0000;
      `CHK("dsg_path", 1'b0, outs.dsg_path_en)
      rd(REG_STATUS, rv);
      `CHK("dsg_oc", 1'b1, rv[1])
      @(posedge sys_clk);
      cur_a <= 16'sh0002;
      tick(4);
      cur_a <= 16'sh0000;
      rd(REG_STATUS, rv);
      `CHK("dsg_oc_rel", 1'b0, rv[1])
      @(posedge sys_clk);
      cur_a <= -16'sh0321;
      tick(14);
      cur_a <= 16'sh0000;
      rd(REG_STATUS, rv);
      `CHK("sc", 2'b10, rv[2:1])
      @(posedge sys_clk);
      load_removed <= 1'b1;
      tick(2);
      load_removed <= 1'b0;
      rd(REG_STATUS, rv);
      `CHK("sc_rel", 1'b0, rv[2])
      $display("test overcurrent done");
      @(posedge sys_clk);
      cmax_mv <= 20'h00fa0;
      cmin_mv <= 20'h00f6e;
      tick(4);
      `CHK("bal", 17'h107d0, {outs.bal_en, outs.bal_lim_ma})
      cmin_mv <= 20'h00f6f;
      tick(4);
      cmax_mv <= 20'h00e74;
      cmin_mv <= 20'h00e74;
      `CHK("bal_off", 1'b0, outs.bal_en)
      for (int i = 0; i < 11; i++) begin
         @(posedge sys_clk);
         bat_c <= t_bat[i];
         fet_c <= t_fet[i];
         tick(4);
         rd(REG_STATUS, rv);
         `CHK("temp_faults", t_exp[i], rv[9:0])
      end
      $display("test temperature done");
      @(posedge sys_clk);
      switch_closed <= 1'b0;
      tick(4);
      `CHK("sleep_outs", 3'b000, {outs.chg_path_en, outs.dsg_path_en, outs.radio_en})
      rd(REG_STATUS, rv);
      `CHK("state", 2'b10, rv[13:12])
      rd(REG_INT_STAT, rv);
      `CHK("sleep_ev", 1'b1, rv[EV_SLEEP])
      @(posedge sys_clk);
      switch_closed <= 1'b1;
      tick(4);
      rd(REG_STATUS, rv);
      `CHK("state", 2'b01, rv[13:12])
      @(posedge sys_clk);
      comm_activity <= 1'b0;
      tick(70);
      rd(REG_STATUS, rv);
      `CHK("state", 2'b10, rv[13:12])
      $display("test sleep done");
      @(posedge sys_clk);
      chg_on        <= 1'b1;
      comm_activity <= 1'b1;
      bat_c         <= 8'sh00;
      tick(6);
      rd(REG_STATUS, rv);
      `CHK("state", 2'b01, rv[13:12])
      `CHK("heat", 1'b1, outs.heater_en)
      @(posedge sys_clk);
      bat_c <= 8'sh05;
      tick(4);
      `CHK("heat_off", 1'b0, outs.heater_en)
      wr(REG_CTRL, 32'h1);
      rd(REG_STATUS, rv);
      `CHK("mom_sw", 3'b100, rv[13:11])
      @(posedge sys_clk);
      switch_closed <= 1'b0;
      tick(2);
      switch_closed <= 1'b1;
      tick(4);
      rd(REG_STATUS, rv);
      `CHK("mom_sw", 3'b011, rv[13:11])
      $display("test charger and switch mode done");
      tally_and_finish();
   end
endmodule : tb_top
